// ==== rst_wdog_map.svh ====
`ifndef RST_WDOG_MAP_SVH
`define RST_WDOG_MAP_SVH

// System clock rate
`define CLK_MHZ        100
// Shortest external reset pulse that is honoured
`define EXT_MIN_NS     2500
`define EXT_MIN_CYC    ((`EXT_MIN_NS * `CLK_MHZ + 999) / 1000)
// Start-up stretch per fuse setting, microseconds
`define SUT_US0        1
`define SUT_US1        2
`define SUT_US2        8
`define SUT_US3        32
`define SUT_CYC0       (`SUT_US0 * `CLK_MHZ)
`define SUT_CYC1       (`SUT_US1 * `CLK_MHZ)
`define SUT_CYC2       (`SUT_US2 * `CLK_MHZ)
`define SUT_CYC3       (`SUT_US3 * `CLK_MHZ)
// Timed sequence window, clock cycles
`define WIN_CYC        4
// Watchdog oscillator and shortest time-out
`define OSC_KHZ        128
`define WD_MIN_MS      16
`define WD_BASE_TICKS  (`WD_MIN_MS * `OSC_KHZ)
`define WD_SEL_MAX     4'h9
// Reset values
`define CAUSE_RST      5'h00
`define CAUSE_POR      5'h01
`define PIN_RST        5'h02

`endif

// ==== rst_wdog_pkg.sv ====
package rst_wdog_pkg;

   typedef struct packed {
      logic       irq_flag;
      logic       irq_en;
      logic       change_en;
      logic       reset_en;
      logic [3:0] prescale;
   } wdog_ctrl_t;

   typedef struct packed {
      logic debug;
      logic wdog;
      logic brownout_detector;
      logic ext;
      logic por;
   } reset_cause_t;

   typedef struct packed {
      logic lock_enable;
      logic lock;
   } lock_req_t;

   typedef enum logic [1:0] {
      RS_HOLD,
      RS_STRETCH,
      RS_RUN
   } rst_state_t;

endpackage

// ==== pin_sync.sv ====
`timescale 1ns/1ns
module pin_sync #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (srst) begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// ==== rst_wdog_ctrl.sv ====
`timescale 1ns/1ns
`include "rst_wdog_map.svh"
// Notes on behaviour
// - I/O registers initialised during reset; restart fetch.
// - Ports return to initial state on any source.
// - Stretch internal reset by fuse-chosen delay.
// - Five reset sources, any resets the core.
// - Long enough external low pulse resets device.
// - Supply below detection level reasserts reset immediately.
// - Watchdog reset is one-cycle pulse, delay follows.
// - Debug reset command resets in debug mode.
// - Brown-out with hysteresis, release after delay.
// - Brown-out fuse keeps detector on except power-off.
// - Watchdog counts oscillator ticks, expiry interrupts/resets.
// - Restart instruction clears watchdog counter.
// - Time-out selectable from 16 ms to 8 s.
// - Interrupt, reset and combined watchdog modes.
// - Watchdog keeps running during sleep.
// - Always-on fuse forces reset mode, interrupt off.
// - Opening write needs change and reset enable.
// - Reset enable and prescale applied only within four-cycle window.
// - Two-step lock freezes config until reset.
// - Combined mode vector clears enable and flag.
// - Flag set on expiry, cleared by vector/write-one.
// - Sticky cause flags; power-on clears others.
module rst_wdog_ctrl
   import rst_wdog_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        supply_below_por,
   input  wire logic        ext_reset_n,
   input  wire logic        bod_below_lower,
   input  wire logic        bod_above_upper,
   input  wire logic        brownout_enable_fuse,
   input  wire logic        power_off_mode,
   input  wire logic [1:0]  startup_time_fuses,
   input  wire logic        debug_mode_active,
   input  wire logic        debug_reset_cmd,
   input  wire logic        wdog_osc,
   input  wire logic        wdog_always_on_fuse,
   input  wire logic        wdog_restart,
   input  wire logic        ctrl_wr,
   input  wire wdog_ctrl_t  ctrl_wdata,
   input  wire logic        lock_wr,
   input  wire lock_req_t   lock_wdata,
   input  wire logic        irq_vector_ack,
   input  wire logic        cause_wr,
   input  wire reset_cause_t cause_wdata,
   output logic             core_reset,
   output logic             io_reset,
   output logic             fetch_start,
   output logic             wdog_irq,
   output wdog_ctrl_t       wdog_ctrl,
   output logic             wdog_cfg_lock,
   output reset_cause_t     reset_cause_status
);
   logic [4:0]  pin_s;
   logic        por_s;
   logic        ext_n_s;
   logic        bod_lo_s;
   logic        bod_hi_s;
   logic        osc_s;
   logic        osc_prev;
   logic        tick;
   logic [11:0] ext_cnt;
   logic        ext_src;
   logic        bod_src;
   logic        dbg_src;
   logic        wd_pulse;
   logic        any_src;
   rst_state_t  state;
   rst_state_t  next_state;
   logic [11:0] dly;
   logic        rst_int;
   logic        reset_en;
   logic        irq_en;
   logic        irq_flag;
   logic [3:0]  prescale;
   logic        chg_open;
   logic [2:0]  chg_cnt;
   logic        lock_open;
   logic [2:0]  lock_cnt;
   logic        cfg_lock;
   logic        act_run;
   logic [3:0]  act_sel;
   logic [3:0]  sel_c;
   logic [20:0] wd_lim;
   logic [19:0] wd_cnt;
   logic        wd_exp;
   logic        chg_apply;

   function automatic logic [11:0] sut_cyc(input logic [1:0] f);
      case (f)
         2'h0:    sut_cyc = 12'(`SUT_CYC0);
         2'h1:    sut_cyc = 12'(`SUT_CYC1);
         2'h2:    sut_cyc = 12'(`SUT_CYC2);
         default: sut_cyc = 12'(`SUT_CYC3);
      endcase
   endfunction

   pin_sync #(.W(5), .RST_VAL(`PIN_RST)) u_pin_sync (
      .clk  (clk),
      .srst (srst),
      .d    ({wdog_osc, bod_above_upper, bod_below_lower, ext_reset_n,
              supply_below_por}),
      .q    (pin_s)
   );

   assign por_s    = pin_s[0];
   assign ext_n_s  = pin_s[1];
   assign bod_lo_s = pin_s[2];
   assign bod_hi_s = pin_s[3];
   assign osc_s    = pin_s[4];
   assign tick     = osc_s & ~osc_prev;
   assign dbg_src  = debug_mode_active & debug_reset_cmd;
   assign any_src  = por_s | ext_src | bod_src | wd_pulse | dbg_src;
   assign rst_int  = srst | core_reset;

   // Short glitches on the reset pin are filtered out
   always_ff @(posedge clk) begin
      if (srst || ext_n_s) begin
         ext_cnt <= 12'h000;
         ext_src <= 1'b0;
      end else if (ext_cnt != 12'(`EXT_MIN_CYC)) begin
         ext_cnt <= ext_cnt + 12'h001;
      end else begin
         ext_src <= 1'b1;
      end
   end

   // Hysteresis: trip below lower trigger, release above upper
   always_ff @(posedge clk) begin
      if (srst || !brownout_enable_fuse || power_off_mode) begin
         bod_src <= 1'b0;
      end else if (bod_lo_s) begin
         bod_src <= 1'b1;
      end else if (bod_hi_s) begin
         bod_src <= 1'b0;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         RS_HOLD:    if (!any_src) next_state = RS_STRETCH;
         RS_STRETCH: begin
            if (any_src) begin
               next_state = RS_HOLD;
            end else if (dly == 12'h000) begin
               next_state = RS_RUN;
            end
         end
         RS_RUN:     if (any_src) next_state = RS_HOLD;
         default:    next_state = RS_HOLD;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state <= RS_HOLD;
         dly   <= 12'h000;
      end else begin
         state <= next_state;
         if (state == RS_HOLD) begin
            dly <= sut_cyc(startup_time_fuses) - 12'h001;
         end else if (state == RS_STRETCH && dly != 12'h000) begin
            dly <= dly - 12'h001;
         end
      end
   end

   // Ports follow sources directly; core release waits for the stretch
   always_ff @(posedge clk) begin
      if (srst) begin
         core_reset  <= 1'b1;
         io_reset    <= 1'b1;
         fetch_start <= 1'b0;
      end else begin
         core_reset  <= next_state != RS_RUN;
         io_reset    <= any_src;
         fetch_start <= state == RS_STRETCH && next_state == RS_RUN;
      end
   end

   // Timed change window for reset enable and prescaler
   assign chg_apply = ctrl_wr && !ctrl_wdata.change_en && chg_open && !cfg_lock;

   always_ff @(posedge clk) begin
      if (rst_int) begin
         chg_open <= 1'b0;
         chg_cnt  <= 3'h0;
      end else if (ctrl_wr && ctrl_wdata.change_en && ctrl_wdata.reset_en && !cfg_lock) begin
         chg_open <= 1'b1;
         chg_cnt  <= 3'(`WIN_CYC);
      end else if (chg_apply || chg_cnt == 3'h1) begin
         chg_open <= 1'b0;
         chg_cnt  <= 3'h0;
      end else if (chg_cnt != 3'h0) begin
         chg_cnt  <= chg_cnt - 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst_int) begin
         reset_en <= wdog_always_on_fuse;
         prescale <= 4'h0;
      end else begin
         if (chg_apply) begin
            reset_en <= ctrl_wdata.reset_en | wdog_always_on_fuse;
            prescale <= ctrl_wdata.prescale;
         end else if (wdog_always_on_fuse) begin
            reset_en <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst_int || wdog_always_on_fuse) begin
         irq_en <= 1'b0;
      end else if (irq_vector_ack && reset_en && irq_en) begin
         irq_en <= 1'b0;
      end else if (ctrl_wr && !cfg_lock) begin
         irq_en <= ctrl_wdata.irq_en;
      end
   end

   // A new expiry beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst_int) begin
         irq_flag <= 1'b0;
      end else if (wd_exp && irq_en) begin
         irq_flag <= 1'b1;
      end else if (irq_vector_ack || (ctrl_wr && ctrl_wdata.irq_flag)) begin
         irq_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst_int) begin
         lock_open <= 1'b0;
         lock_cnt  <= 3'h0;
         cfg_lock  <= 1'b0;
      end else if (lock_wr && lock_wdata.lock_enable && lock_wdata.lock) begin
         lock_open <= 1'b1;
         lock_cnt  <= 3'(`WIN_CYC);
      end else if (lock_wr && lock_open && lock_wdata.lock) begin
         lock_open <= 1'b0;
         lock_cnt  <= 3'h0;
         cfg_lock  <= 1'b1;
      end else if (lock_cnt == 3'h1) begin
         lock_open <= 1'b0;
         lock_cnt  <= 3'h0;
      end else if (lock_cnt != 3'h0) begin
         lock_cnt  <= lock_cnt - 3'h1;
      end
   end

   // Counter side takes its settings only on an oscillator tick
   always_ff @(posedge clk) begin
      if (rst_int) begin
         osc_prev <= 1'b0;
         act_run  <= 1'b0;
         act_sel  <= 4'h0;
      end else begin
         osc_prev <= osc_s;
         if (tick) begin
            act_run <= reset_en | irq_en;
            act_sel <= prescale;
         end
      end
   end

   assign sel_c  = (act_sel > `WD_SEL_MAX) ? `WD_SEL_MAX : act_sel;
   assign wd_lim = 21'(`WD_BASE_TICKS) << sel_c;

   // No sleep gating: the counter keeps running in every sleep mode
   always_ff @(posedge clk) begin
      if (rst_int || wdog_restart || !act_run) begin
         wd_cnt <= 20'h00000;
         wd_exp <= 1'b0;
      end else if (tick && {1'b0, wd_cnt} == wd_lim - 21'h000001) begin
         wd_cnt <= 20'h00000;
         wd_exp <= 1'b1;
      end else begin
         wd_cnt <= tick ? wd_cnt + 20'h00001 : wd_cnt;
         wd_exp <= 1'b0;
      end
   end

   // Combined mode: an expiry resets once the vector has cleared irq_en, or while irq_flag is still set
   always_ff @(posedge clk) begin
      if (srst) begin
         wd_pulse <= 1'b0;
      end else begin
         wd_pulse <= wd_exp && reset_en && (!irq_en || irq_flag);
      end
   end

   // Cause flags survive internal resets so software can read them
   always_ff @(posedge clk) begin
      if (srst) begin
         reset_cause_status <= `CAUSE_RST;
      end else if (por_s) begin
         reset_cause_status <= `CAUSE_POR;
      end else begin
         reset_cause_status.por   <= reset_cause_status.por &
                                     ~(cause_wr & ~cause_wdata.por);
         reset_cause_status.ext   <= ext_src | (reset_cause_status.ext &
                                     ~(cause_wr & ~cause_wdata.ext));
         reset_cause_status.brownout_detector   <= bod_src | (reset_cause_status.brownout_detector &
                                     ~(cause_wr & ~cause_wdata.brownout_detector));
         reset_cause_status.wdog  <= wd_pulse | (reset_cause_status.wdog &
                                     ~(cause_wr & ~cause_wdata.wdog));
         reset_cause_status.debug <= dbg_src | (reset_cause_status.debug &
                                     ~(cause_wr & ~cause_wdata.debug));
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wdog_irq <= 1'b0;
      end else begin
         wdog_irq <= irq_flag & irq_en;
      end
   end

   assign wdog_ctrl     = '{irq_flag:  irq_flag,  irq_en:   irq_en,
                            change_en: chg_open,  reset_en: reset_en,
                            prescale:  prescale};
   assign wdog_cfg_lock = cfg_lock;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_por_now;
      por_s |=> core_reset && io_reset;
   endproperty
   a_por_now: assert property (p_por_now) else $error("por not immediate");

   property p_any_src;
      any_src |=> io_reset && core_reset;
   endproperty
   a_any_src: assert property (p_any_src) else $error("source ignored");

   property p_stretch;
      $fell(io_reset) |-> core_reset;
   endproperty
   a_stretch: assert property (p_stretch) else $error("no stretch");

   property p_wd_one;
      wd_pulse |=> !wd_pulse;
   endproperty
   a_wd_one: assert property (p_wd_one) else $error("wdog pulse too long");

   property p_restart;
      wdog_restart |=> wd_cnt == 20'h00000;
   endproperty
   a_restart: assert property (p_restart) else $error("restart missed");

   property p_always_on;
      wdog_always_on_fuse && $past(wdog_always_on_fuse) |-> reset_en && !irq_en;
   endproperty
   a_always_on: assert property (p_always_on) else $error("fuse not forcing");

   property p_no_window;
      ctrl_wr && !chg_open && !core_reset |=> $stable(prescale);
   endproperty
   a_no_window: assert property (p_no_window) else $error("write outside window");

   property p_win_close;
      $rose(chg_open) ##1 !ctrl_wr [*4] |=> !chg_open;
   endproperty
   a_win_close: assert property (p_win_close) else $error("window stuck");

   property p_locked;
      cfg_lock && !core_reset |=> cfg_lock && $stable(prescale);
   endproperty
   a_locked: assert property (p_locked) else $error("lock broken");

   property p_comb_ack;
      irq_vector_ack && reset_en && irq_en && !wd_exp && !core_reset
         |=> !irq_en && !irq_flag;
   endproperty
   a_comb_ack: assert property (p_comb_ack) else $error("vector no clear");

   property p_flag_set;
      wd_exp && irq_en && !core_reset |=> irq_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set");

   property p_por_cause;
      por_s |=> reset_cause_status == `CAUSE_POR;
   endproperty
   a_por_cause: assert property (p_por_cause) else $error("por cause wrong");

   property p_bod_off;
      power_off_mode |=> !bod_src;
   endproperty
   a_bod_off: assert property (p_bod_off) else $error("bod on in off");

   c_wd_reset:  cover property (wd_pulse);
   c_fetch:     cover property (fetch_start);
   c_lock:      cover property ($rose(cfg_lock));
   c_irq:       cover property ($rose(irq_flag));
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ns
`include "rst_wdog_map.svh"
module tb_top
   import rst_wdog_pkg::*;
;
   logic         clk, srst, supply_below_por, ext_reset_n, bod_below_lower, bod_above_upper;
   logic         brownout_enable_fuse, power_off_mode, debug_mode_active, debug_reset_cmd;
   logic [1:0]   startup_time_fuses;
   logic         wdog_osc, wdog_always_on_fuse, wdog_restart, ctrl_wr, lock_wr;
   logic         irq_vector_ack, cause_wr, core_reset, io_reset, fetch_start, wdog_irq;
   logic         wdog_cfg_lock;
   wdog_ctrl_t   ctrl_wdata, wdog_ctrl;
   lock_req_t    lock_wdata;
   reset_cause_t cause_wdata, reset_cause_status;
   int           n_mismatch, tests_run, cycles, n;

   rst_wdog_ctrl dut (
      .clk(clk), .srst(srst), .supply_below_por(supply_below_por),
      .ext_reset_n(ext_reset_n), .bod_below_lower(bod_below_lower),
      .bod_above_upper(bod_above_upper), .brownout_enable_fuse(brownout_enable_fuse),
      .power_off_mode(power_off_mode), .startup_time_fuses(startup_time_fuses),
      .debug_mode_active(debug_mode_active), .debug_reset_cmd(debug_reset_cmd),
      .wdog_osc(wdog_osc), .wdog_always_on_fuse(wdog_always_on_fuse),
      .wdog_restart(wdog_restart), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
      .lock_wr(lock_wr), .lock_wdata(lock_wdata), .irq_vector_ack(irq_vector_ack),
      .cause_wr(cause_wr), .cause_wdata(cause_wdata), .core_reset(core_reset),
      .io_reset(io_reset), .fetch_start(fetch_start), .wdog_irq(wdog_irq),
      .wdog_ctrl(wdog_ctrl), .wdog_cfg_lock(wdog_cfg_lock),
      .reset_cause_status(reset_cause_status)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Oscillator sped up to 8 clocks a tick so time-outs fit the run
   initial begin
      wdog_osc = 1'b0;
      forever #40 wdog_osc = ~wdog_osc;
   end

   task automatic print_verdict();
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   task automatic wr_ctrl(input wdog_ctrl_t v);
      @(posedge clk);
      ctrl_wr    <= 1'b1;
      ctrl_wdata <= v;
      @(posedge clk);
      ctrl_wr    <= 1'b0;
   endtask

   // Opening write keeps the old prescale so no early time-out
   task automatic timed(input logic re, input logic [3:0] ps, input logic ie);
      wr_ctrl({1'b0, ie, 1'b1, 1'b1, wdog_ctrl.prescale});
      wr_ctrl({1'b0, ie, 1'b0, re, ps});
      cyc(1);
   endtask

   task automatic clear_causes();
      @(posedge clk);
      cause_wr    <= 1'b1;
      cause_wdata <= 5'h00;
      @(posedge clk);
      cause_wr    <= 1'b0;
      cyc(1);
      check("cause cleared", 16'(reset_cause_status), 16'h0000);
   endtask

   task automatic see_reset(input int lim);
      int k;
      k = 0;
      while (core_reset !== 1'b1 && k < lim) begin
         @(posedge clk);
         k++;
      end
      check("core_reset", 16'(core_reset), 16'h0001);
   endtask

   task automatic wait_fetch(output int k);
      k = 0;
      while (fetch_start !== 1'b1 && k < 5000) begin
         @(posedge clk);
         k++;
      end
      check("fetch_start", 16'(fetch_start), 16'h0001);
      check("core_reset low", 16'(core_reset), 16'h0000);
   endtask

   task automatic wait_io_low();
      int k;
      k = 0;
      while (io_reset !== 1'b0 && k < 50) begin
         @(posedge clk);
         k++;
      end
   endtask

   task automatic pulse_restart();
      @(posedge clk);
      wdog_restart <= 1'b1;
      @(posedge clk);
      wdog_restart <= 1'b0;
   endtask

   task automatic t_bod();
      clear_causes();
      startup_time_fuses   <= 2'b01;
      brownout_enable_fuse <= 1'b1;
      power_off_mode       <= 1'b1;
      bod_below_lower      <= 1'b1;
      cyc(10);
      check("bod in power-off", 16'(io_reset), 16'h0000);
      power_off_mode <= 1'b0;
      cyc(5);
      check("bod io_reset", 16'(io_reset), 16'h0001);
      check("bod core_reset", 16'(core_reset), 16'h0001);
      bod_below_lower <= 1'b0;
      bod_above_upper <= 1'b1;
      wait_io_low();
      wait_fetch(n);
      check("bod stretch", 16'(n >= `SUT_CYC1 - 1 && n <= `SUT_CYC1 + 3), 16'h0001);
      check("bod cause", 16'(reset_cause_status), 16'h0004);
   endtask

   task automatic t_ext();
      clear_causes();
      startup_time_fuses <= 2'b00;
      @(posedge clk);
      ext_reset_n <= 1'b0;
      cyc(200);
      ext_reset_n <= 1'b1;
      cyc(10);
      check("short ext pulse", 16'(core_reset), 16'h0000);
      ext_reset_n <= 1'b0;
      cyc(300);
      check("long ext pulse", 16'(io_reset), 16'h0001);
      ext_reset_n <= 1'b1;
      wait_io_low();
      wait_fetch(n);
      check("ext stretch", 16'(n >= `SUT_CYC0 - 1 && n <= `SUT_CYC0 + 3), 16'h0001);
      check("ext cause", 16'(reset_cause_status), 16'h0002);
   endtask

   task automatic t_debug();
      clear_causes();
      @(posedge clk);
      debug_reset_cmd <= 1'b1;
      @(posedge clk);
      debug_reset_cmd <= 1'b0;
      cyc(4);
      check("cmd outside debug", 16'(core_reset), 16'h0000);
      debug_mode_active <= 1'b1;
      debug_reset_cmd   <= 1'b1;
      @(posedge clk);
      debug_reset_cmd <= 1'b0;
      see_reset(4);
      debug_mode_active <= 1'b0;
      wait_fetch(n);
      check("debug cause", 16'(reset_cause_status), 16'h0010);
   endtask

   task automatic t_timed();
      wr_ctrl({1'b0, 1'b0, 1'b1, 1'b0, 4'h0});
      cyc(1);
      check("open without reset_en", 16'(wdog_ctrl.change_en), 16'h0000);
      wr_ctrl({1'b0, 1'b0, 1'b0, 1'b1, 4'h3});
      cyc(1);
      check("apply refused", 16'(wdog_ctrl), 16'h0000);
      timed(1'b0, 4'h5, 1'b0);
      check("apply in window", 16'(wdog_ctrl), 16'h0005);
      wr_ctrl({1'b0, 1'b0, 1'b1, 1'b1, 4'h5});
      cyc(1);
      check("window open", 16'(wdog_ctrl.change_en), 16'h0001);
      cyc(5);
      check("window closed", 16'(wdog_ctrl.change_en), 16'h0000);
      wr_ctrl({1'b0, 1'b0, 1'b0, 1'b1, 4'h2});
      cyc(1);
      check("late apply", 16'(wdog_ctrl), 16'h0005);
      @(posedge clk);
      lock_wr    <= 1'b1;
      lock_wdata <= 2'b11;
      @(posedge clk);
      lock_wdata <= 2'b01;
      @(posedge clk);
      lock_wr    <= 1'b0;
      cyc(1);
      check("lock set", 16'(wdog_cfg_lock), 16'h0001);
      timed(1'b1, 4'h7, 1'b1);
      check("locked config", 16'(wdog_ctrl), 16'h0005);
      @(posedge clk);
      srst <= 1'b1;
      cyc(3);
      srst <= 1'b0;
      wait_fetch(n);
      check("lock after reset", 16'(wdog_cfg_lock), 16'h0000);
   endtask

   task automatic t_wdog();
      timed(1'b0, 4'h0, 1'b1);
      pulse_restart();
      cyc(1500 * 8);
      check("flag before restart", 16'(wdog_ctrl.irq_flag), 16'h0000);
      pulse_restart();
      n = 0;
      while (wdog_ctrl.irq_flag !== 1'b1 && n < 20000) begin
         @(posedge clk);
         n++;
      end
      check("irq time-out", 16'(n >= 16360 && n <= 16420), 16'h0001);
      cyc(2);
      check("wdog_irq", 16'(wdog_irq), 16'h0001);
      check("no reset in irq mode", 16'(core_reset), 16'h0000);
      wr_ctrl({1'b1, 1'b0, 1'b0, 1'b0, 4'h0});
      cyc(2);
      check("flag write-one", 16'(wdog_ctrl.irq_flag), 16'h0000);
      check("wdog_irq cleared", 16'(wdog_irq), 16'h0000);
      clear_causes();
      timed(1'b1, 4'h0, 1'b1);
      pulse_restart();
      n = 0;
      while (wdog_ctrl.irq_flag !== 1'b1 && n < 20000) begin
         @(posedge clk);
         n++;
      end
      check("combined first expiry", 16'(core_reset), 16'h0000);
      @(posedge clk);
      irq_vector_ack <= 1'b1;
      @(posedge clk);
      irq_vector_ack <= 1'b0;
      cyc(1);
      check("vector clears", 16'({wdog_ctrl.irq_flag, wdog_ctrl.irq_en}), 16'h0000);
      check("stays reset mode", 16'(wdog_ctrl.reset_en), 16'h0001);
      see_reset(20000);
      n = 0;
      repeat (6) begin
         if (io_reset === 1'b1) begin
            n++;
         end
         @(posedge clk);
      end
      check("wdog pulse width", 16'(n), 16'h0001);
      wait_fetch(n);
      check("wdog cause", 16'(reset_cause_status), 16'h0008);
      check("ctrl after reset", 16'(wdog_ctrl), 16'h0000);
   endtask

   task automatic t_por_fuse();
      supply_below_por <= 1'b1;
      see_reset(5);
      cyc(2);
      check("por clears others", 16'(reset_cause_status), 16'(`CAUSE_POR));
      supply_below_por    <= 1'b0;
      wdog_always_on_fuse <= 1'b1;
      wait_fetch(n);
      check("fuse reset_en", 16'(wdog_ctrl.reset_en), 16'h0001);
      wr_ctrl({1'b0, 1'b1, 1'b0, 1'b0, 4'h0});
      cyc(1);
      check("fuse irq_en", 16'(wdog_ctrl.irq_en), 16'h0000);
      timed(1'b0, 4'h0, 1'b0);
      check("fuse holds reset_en", 16'(wdog_ctrl.reset_en), 16'h0001);
   endtask

   initial begin
      n_mismatch = 0;
      tests_run = 0;
      cycles = 0;
      srst = 1'b1;
      supply_below_por = 1'b1;
      ext_reset_n = 1'b1;
      bod_below_lower = 1'b0;
      bod_above_upper = 1'b1;
      brownout_enable_fuse = 1'b0;
      power_off_mode = 1'b0;
      startup_time_fuses = 2'b00;
      debug_mode_active = 1'b0;
      debug_reset_cmd = 1'b0;
      wdog_always_on_fuse = 1'b0;
      wdog_restart = 1'b0;
      ctrl_wr = 1'b0;
      ctrl_wdata = '0;
      lock_wr = 1'b0;
      lock_wdata = '0;
      irq_vector_ack = 1'b0;
      cause_wr = 1'b0;
      cause_wdata = '0;
      cyc(20);
      srst <= 1'b0;
      cyc(5);
      check("reset held", 16'({io_reset, core_reset}), 16'h0003);
      supply_below_por <= 1'b0;
      wait_fetch(n);
      check("por cause", 16'(reset_cause_status), 16'(`CAUSE_POR));
      check("ctrl reset value", 16'(wdog_ctrl), 16'h0000);
      t_bod();
      t_ext();
      t_debug();
      t_timed();
      t_wdog();
      t_por_fuse();
      print_verdict();
   end
endmodule
